// *** design/msp_consts.svh ***
// Constants for the serial port setup block: register offsets, codes and timing.
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH
`define MSP_OFS_ENABLE 16'h1392
`define MSP_OFS_ROLE 16'h1393
`define MSP_OFS_REALSEL 16'h1394
`define MSP_OFS_RSTART 16'h1395
`define MSP_OFS_RBASE 16'h1396
`define MSP_OFS_FRAMING 16'h1397
`define MSP_OFS_RATE 16'h1398
`define MSP_OFS_PARITY 16'h1399
`define MSP_OFS_CHARLEN 16'h139a
`define MSP_OFS_STOPLEN 16'h139b
`define MSP_OFS_RTSLEAD 16'h139c
`define MSP_OFS_RTSTRAIL 16'h139d
`define MSP_OFS_REPLYMIN 16'h139e
`define MSP_OFS_CTSGATE 16'h139f
`define MSP_OFS_NODE 16'h13a0
`define MSP_OFS_DIBASE 16'h13a1
`define MSP_OFS_IRBASE 16'h13a2
`define MSP_CLK_HZ 32'd50000000
`define MSP_TICK_MS_CYCLES (`MSP_CLK_HZ / 32'd1000)
`define MSP_RATE_384 16'h0180
`define MSP_RATE_576 16'h0240
`define MSP_RATE_115 16'h0073
`define MSP_BPS_384 32'd38400
`define MSP_BPS_576 32'd57600
`define MSP_BPS_115 32'd115000
`define MSP_PAR_ODD 16'h0001
`define MSP_PAR_EVEN 16'h0002
`define MSP_FC_DISCRETE 8'h02
`define MSP_FC_HOLD_RD 8'h03
`define MSP_FC_INPUT 8'h04
`define MSP_FC_HOLD_WR1 8'h06
`define MSP_FC_HOLD_WRN 8'h10
`define MSP_ONE16 16'h0001
`define MSP_TWO16 16'h0002
`define MSP_RST_CHARLEN 16'h0008
`define MSP_RST_RATE 16'h2580
`define MSP_FIFO_DEPTH 32
`endif

// *** design/msp_pkg.sv ***
// Types shared by the serial port setup block.
package msp_pkg;
    typedef struct packed {
        logic [15:0] port_enable;
        logic [15:0] port_role;
        logic [15:0] real_value_select;
        logic [15:0] real_region_start;
        logic [15:0] real_region_base;
        logic [15:0] framing_select;
        logic [15:0] line_rate;
        logic [15:0] parity_code;
        logic [15:0] char_length;
        logic [15:0] stop_length;
        logic [15:0] rts_lead_delay;
        logic [15:0] rts_trail_delay;
        logic [15:0] reply_min_delay;
        logic [15:0] cts_gate_select;
        logic [15:0] node_address;
        logic [15:0] discrete_input_base;
        logic [15:0] input_register_base;
    } msp_cfg_type;
    typedef struct packed {
        logic [7:0] node;
        logic [7:0] func;
        logic [15:0] addr;
    } msp_req_type;
    typedef struct packed {
        logic hit;
        logic is_real;
        logic [15:0] db_addr;
    } msp_map_type;
    typedef enum logic [2:0] {
        MSP_TX_IDLE, MSP_TX_REPLY_WAIT, MSP_TX_LEAD, MSP_TX_SEND, MSP_TX_TRAIL
    } msp_tx_state_type;
endpackage

// *** design/msp_fifo.sv ***
// Byte FIFO in front of the transmitter.
`timescale 1ns/100ps
`default_nettype none
module msp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// *** design/msp_port.sv ***
// Modbus serial port: configuration words, request mapping and character transmitter.
//
// Contract
// - enable word 0 idles port, 1 runs it
// - role word 0 master, 1 slave
// - real select applies to functions 3, 6, 16
// - real select on: addr >= start is real
// - real request maps to region base plus offset
// - rate word literal, except 384, 576, 115
// - parity 0 none, 1 odd, 2 even
// - data bits 5 through 8 per character
// - one or two stop bits per character
// - raise RTS, wait lead delay, then send
// - hold RTS trail delay after last byte
// - wait minimum response delay before reply
// - CTS gate word 1 waits for CTS high
// - serve only requests for our node address
// - function 2 adds discrete input base
// - function 4 adds input register base
`timescale 1ns/100ps
`default_nettype none
`include "msp_consts.svh"
module msp_port
    import msp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration word port from the host
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    // Decoded request from the frame receiver
    input wire logic req_valid,
    input wire msp_req_type req,
    output msp_map_type req_map,
    // Outgoing message bytes
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_is_reply,
    // Serial pins
    output logic txd,
    output logic rts,
    input wire logic cts,
    // Port mode status
    output logic port_active,
    output logic slave_mode,
    output logic ascii_mode,
    output logic tx_busy
);
    // ------------------------------------------------------------
    // Configuration words
    // ------------------------------------------------------------
    msp_cfg_type cfg_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= '0;
            cfg_reg.char_length <= `MSP_RST_CHARLEN;
            cfg_reg.stop_length <= `MSP_ONE16;
            cfg_reg.line_rate <= `MSP_RST_RATE;
        end else if (cfg_wr) begin
            unique case (cfg_addr)
                `MSP_OFS_ENABLE: cfg_reg.port_enable <= cfg_wdata;
                `MSP_OFS_ROLE: cfg_reg.port_role <= cfg_wdata;
                `MSP_OFS_REALSEL: cfg_reg.real_value_select <= cfg_wdata;
                `MSP_OFS_RSTART: cfg_reg.real_region_start <= cfg_wdata;
                `MSP_OFS_RBASE: cfg_reg.real_region_base <= cfg_wdata;
                `MSP_OFS_FRAMING: cfg_reg.framing_select <= cfg_wdata;
                `MSP_OFS_RATE: cfg_reg.line_rate <= cfg_wdata;
                `MSP_OFS_PARITY: cfg_reg.parity_code <= cfg_wdata;
                `MSP_OFS_CHARLEN: cfg_reg.char_length <= cfg_wdata;
                `MSP_OFS_STOPLEN: cfg_reg.stop_length <= cfg_wdata;
                `MSP_OFS_RTSLEAD: cfg_reg.rts_lead_delay <= cfg_wdata;
                `MSP_OFS_RTSTRAIL: cfg_reg.rts_trail_delay <= cfg_wdata;
                `MSP_OFS_REPLYMIN: cfg_reg.reply_min_delay <= cfg_wdata;
                `MSP_OFS_CTSGATE: cfg_reg.cts_gate_select <= cfg_wdata;
                `MSP_OFS_NODE: cfg_reg.node_address <= cfg_wdata;
                `MSP_OFS_DIBASE: cfg_reg.discrete_input_base <= cfg_wdata;
                `MSP_OFS_IRBASE: cfg_reg.input_register_base <= cfg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (cfg_addr)
            `MSP_OFS_ENABLE: cfg_rdata = cfg_reg.port_enable;
            `MSP_OFS_ROLE: cfg_rdata = cfg_reg.port_role;
            `MSP_OFS_REALSEL: cfg_rdata = cfg_reg.real_value_select;
            `MSP_OFS_RSTART: cfg_rdata = cfg_reg.real_region_start;
            `MSP_OFS_RBASE: cfg_rdata = cfg_reg.real_region_base;
            `MSP_OFS_FRAMING: cfg_rdata = cfg_reg.framing_select;
            `MSP_OFS_RATE: cfg_rdata = cfg_reg.line_rate;
            `MSP_OFS_PARITY: cfg_rdata = cfg_reg.parity_code;
            `MSP_OFS_CHARLEN: cfg_rdata = cfg_reg.char_length;
            `MSP_OFS_STOPLEN: cfg_rdata = cfg_reg.stop_length;
            `MSP_OFS_RTSLEAD: cfg_rdata = cfg_reg.rts_lead_delay;
            `MSP_OFS_RTSTRAIL: cfg_rdata = cfg_reg.rts_trail_delay;
            `MSP_OFS_REPLYMIN: cfg_rdata = cfg_reg.reply_min_delay;
            `MSP_OFS_CTSGATE: cfg_rdata = cfg_reg.cts_gate_select;
            `MSP_OFS_NODE: cfg_rdata = cfg_reg.node_address;
            `MSP_OFS_DIBASE: cfg_rdata = cfg_reg.discrete_input_base;
            `MSP_OFS_IRBASE: cfg_rdata = cfg_reg.input_register_base;
            default: cfg_rdata = 16'h0000;
        endcase
    end

    assign port_active = (cfg_reg.port_enable == `MSP_ONE16);
    assign slave_mode = (cfg_reg.port_role == `MSP_ONE16);
    // The receiver and transmitter framers outside this block follow this level.
    assign ascii_mode = (cfg_reg.framing_select == `MSP_ONE16);

    // ------------------------------------------------------------
    // Request address mapping
    // ------------------------------------------------------------
    function automatic logic is_holding(input logic [7:0] fc);
        return (fc == `MSP_FC_HOLD_RD) || (fc == `MSP_FC_HOLD_WR1) || (fc == `MSP_FC_HOLD_WRN);
    endfunction

    msp_map_type map_next;
    always_comb begin
        map_next.hit = req_valid && port_active && slave_mode
                       && ({8'h00, req.node} == cfg_reg.node_address);
        map_next.is_real = (cfg_reg.real_value_select != 16'h0000) && is_holding(req.func)
                           && (req.addr >= cfg_reg.real_region_start);
        if (map_next.is_real) begin
            map_next.db_addr = cfg_reg.real_region_base + (req.addr - cfg_reg.real_region_start);
        end else if (req.func == `MSP_FC_DISCRETE) begin
            map_next.db_addr = cfg_reg.discrete_input_base + req.addr;
        end else if (req.func == `MSP_FC_INPUT) begin
            map_next.db_addr = cfg_reg.input_register_base + req.addr;
        end else begin
            map_next.db_addr = req.addr;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            req_map <= '0;
        end else begin
            req_map <= map_next;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick and bit rate
    // ------------------------------------------------------------
    logic [31:0] ms_cnt_reg;
    logic ms_tick;
    assign ms_tick = (ms_cnt_reg == `MSP_TICK_MS_CYCLES - 32'd1);
    always_ff @(posedge clock) begin
        if (rst || ms_tick) begin
            ms_cnt_reg <= 32'd0;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'd1;
        end
    end

    logic [31:0] bps;
    always_comb begin
        unique case (cfg_reg.line_rate)
            `MSP_RATE_384: bps = `MSP_BPS_384;
            `MSP_RATE_576: bps = `MSP_BPS_576;
            `MSP_RATE_115: bps = `MSP_BPS_115;
            default: bps = {16'h0000, cfg_reg.line_rate};
        endcase
    end

    // Division is costly but the rate word changes rarely; a zero rate stalls.
    logic [31:0] bit_cycles;
    assign bit_cycles = (bps == 32'd0) ? 32'hffffffff : (`MSP_CLK_HZ / bps);
    logic [31:0] bit_cnt_reg;
    logic bit_tick;
    assign bit_tick = (bit_cnt_reg + 32'd1 >= bit_cycles);

    // ------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------
    logic fifo_valid;
    logic fifo_ready;
    logic [9:0] fifo_data;
    msp_fifo #(.WIDTH(10), .DEPTH(`MSP_FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(tx_valid && port_active),
        .in_ready(tx_ready),
        .in_data({tx_is_reply, tx_last, tx_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // Transmitter sequencing
    // ------------------------------------------------------------
    msp_tx_state_type st_reg;
    logic [15:0] ms_left_reg;
    logic [11:0] shift_reg;
    logic [3:0] bits_left_reg;
    logic last_reg;
    logic cts_ok;
    logic [3:0] nbits;
    logic parity_bit;
    logic has_parity;
    assign cts_ok = (cfg_reg.cts_gate_select != `MSP_ONE16) || cts;
    assign has_parity = (cfg_reg.parity_code == `MSP_PAR_ODD) || (cfg_reg.parity_code == `MSP_PAR_EVEN);

    function automatic logic [7:0] data_mask(input logic [15:0] len);
        unique case (len)
            16'h0005: return 8'h1f;
            16'h0006: return 8'h3f;
            16'h0007: return 8'h7f;
            default: return 8'hff;
        endcase
    endfunction

    logic [3:0] dlen;
    logic [7:0] dbyte;
    always_comb begin
        unique case (cfg_reg.char_length)
            16'h0005: dlen = 4'd5;
            16'h0006: dlen = 4'd6;
            16'h0007: dlen = 4'd7;
            default: dlen = 4'd8;
        endcase
        dbyte = fifo_data[7:0] & data_mask(cfg_reg.char_length);
        parity_bit = (^dbyte) ^ (cfg_reg.parity_code == `MSP_PAR_ODD);
        nbits = 4'd1 + dlen + {3'd0, has_parity}
                + ((cfg_reg.stop_length == `MSP_TWO16) ? 4'd2 : 4'd1);
    end

    // Start bit, data LSB first, optional parity, stop bits (ones shift in).
    logic [11:0] frame;
    always_comb begin
        frame = 12'hfff;
        frame[0] = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(dlen)) begin
                frame[i + 1] = dbyte[i];
            end
        end
        if (has_parity) begin
            frame[dlen + 4'd1] = parity_bit;
        end
    end

    logic char_start;
    assign char_start = (st_reg == MSP_TX_SEND) && (bits_left_reg == 4'd0) && !last_reg
                        && fifo_valid && cts_ok;
    assign fifo_ready = char_start;
    assign tx_busy = (st_reg != MSP_TX_IDLE);

    always_ff @(posedge clock) begin
        if (rst) begin
            bit_cnt_reg <= 32'd0;
        end else if (char_start || bit_tick) begin
            bit_cnt_reg <= 32'd0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 32'd1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= MSP_TX_IDLE;
            ms_left_reg <= 16'h0000;
            shift_reg <= 12'hfff;
            bits_left_reg <= 4'd0;
            last_reg <= 1'b0;
            rts <= 1'b0;
        end else if (!port_active) begin
            st_reg <= MSP_TX_IDLE;
            rts <= 1'b0;
            bits_left_reg <= 4'd0;
            shift_reg <= 12'hfff;
            last_reg <= 1'b0;
        end else begin
            unique case (st_reg)
                MSP_TX_IDLE: begin
                    last_reg <= 1'b0;
                    if (fifo_valid) begin
                        if (fifo_data[9]) begin
                            st_reg <= MSP_TX_REPLY_WAIT;
                            ms_left_reg <= cfg_reg.reply_min_delay;
                        end else begin
                            st_reg <= MSP_TX_LEAD;
                            ms_left_reg <= cfg_reg.rts_lead_delay;
                            rts <= 1'b1;
                        end
                    end
                end
                MSP_TX_REPLY_WAIT: begin
                    if (ms_left_reg == 16'h0000) begin
                        st_reg <= MSP_TX_LEAD;
                        ms_left_reg <= cfg_reg.rts_lead_delay;
                        rts <= 1'b1;
                    end else if (ms_tick) begin
                        ms_left_reg <= ms_left_reg - 16'h0001;
                    end
                end
                MSP_TX_LEAD: begin
                    if (ms_left_reg == 16'h0000) begin
                        st_reg <= MSP_TX_SEND;
                    end else if (ms_tick) begin
                        ms_left_reg <= ms_left_reg - 16'h0001;
                    end
                end
                MSP_TX_SEND: begin
                    if (char_start) begin
                        shift_reg <= frame;
                        bits_left_reg <= nbits;
                        last_reg <= fifo_data[8];
                    end else if (bits_left_reg != 4'd0) begin
                        if (bit_tick) begin
                            shift_reg <= {1'b1, shift_reg[11:1]};
                            bits_left_reg <= bits_left_reg - 4'd1;
                        end
                    end else if (last_reg) begin
                        st_reg <= MSP_TX_TRAIL;
                        ms_left_reg <= cfg_reg.rts_trail_delay;
                    end
                end
                MSP_TX_TRAIL: begin
                    if (ms_left_reg == 16'h0000) begin
                        st_reg <= MSP_TX_IDLE;
                        rts <= 1'b0;
                    end else if (ms_tick) begin
                        ms_left_reg <= ms_left_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    assign txd = shift_reg[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_idle_when_off;
        @(posedge clock) disable iff (rst) !port_active |=> (st_reg == MSP_TX_IDLE) && !rts;
    endproperty
    a_idle_when_off: assert property (p_idle_when_off) else $error("port not idle while disabled");

    property p_hit_needs_slave;
        @(posedge clock) disable iff (rst) req_map.hit |-> $past(slave_mode) && $past(port_active);
    endproperty
    a_hit_needs_slave: assert property (p_hit_needs_slave) else $error("request served outside slave mode");

    property p_node_match;
        @(posedge clock) disable iff (rst)
            req_map.hit |-> ({8'h00, $past(req.node)} == $past(cfg_reg.node_address));
    endproperty
    a_node_match: assert property (p_node_match) else $error("request for another node served");

    property p_real_map;
        @(posedge clock) disable iff (rst)
            req_map.is_real |-> (req_map.db_addr == 16'($past(cfg_reg.real_region_base) + $past(req.addr)
                - $past(cfg_reg.real_region_start))) && $past(req.addr) >= $past(cfg_reg.real_region_start);
    endproperty
    a_real_map: assert property (p_real_map) else $error("real region mapping wrong");

    property p_discrete_map;
        @(posedge clock) disable iff (rst)
            ($past(req.func) == `MSP_FC_DISCRETE) |->
            (req_map.db_addr == 16'($past(cfg_reg.discrete_input_base) + $past(req.addr)));
    endproperty
    a_discrete_map: assert property (p_discrete_map) else $error("discrete input mapping wrong");

    property p_input_map;
        @(posedge clock) disable iff (rst)
            ($past(req.func) == `MSP_FC_INPUT) |->
            (req_map.db_addr == 16'($past(cfg_reg.input_register_base) + $past(req.addr)));
    endproperty
    a_input_map: assert property (p_input_map) else $error("input register mapping wrong");

    property p_cts_gate;
        @(posedge clock) disable iff (rst) $fell(txd) && $past(bits_left_reg) == 4'd0
            |-> $past(cts) || $past(cfg_reg.cts_gate_select) != `MSP_ONE16;
    endproperty
    a_cts_gate: assert property (p_cts_gate) else $error("character started without clear to send");

    property p_rts_before_data;
        @(posedge clock) disable iff (rst) char_start |-> rts;
    endproperty
    a_rts_before_data: assert property (p_rts_before_data) else $error("data sent with request to send low");

    property p_tick_period;
        @(posedge clock) disable iff (rst) ms_tick |=> !ms_tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("millisecond tick too frequent");
endmodule
`default_nettype wire

// *** verif/msp_line_peer.sv ***
// Far-side receiver that decodes the characters sent on the serial line.
`timescale 1ns/100ps
`default_nettype none
module msp_line_peer (
    // Line
    input wire logic clock,
    input wire logic txd,
    // Expected character format
    input wire logic [31:0] bit_cycles,
    input wire logic [3:0] nbits,
    input wire logic [1:0] parity,
    input wire logic [1:0] nstop,
    // Decoded result
    output logic [7:0] got_byte,
    output logic got_err,
    output logic [15:0] n_got
);
    logic acc;
    initial begin
        n_got = 16'h0000;
        got_byte = 8'h00;
        got_err = 1'b0;
    end
    // Samples mid-bit, so a small error in the bit period does no harm.
    always begin
        @(negedge txd);
        repeat (bit_cycles / 2) @(posedge clock);
        got_err = txd;
        got_byte = 8'h00;
        acc = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_cycles) @(posedge clock);
            got_byte[i] = txd;
            acc = acc ^ txd;
        end
        if (parity != 2'h0) begin
            repeat (bit_cycles) @(posedge clock);
            got_err = got_err | ((acc ^ txd) != (parity == 2'h1));
        end
        for (int i = 0; i < nstop; i++) begin
            repeat (bit_cycles) @(posedge clock);
            got_err = got_err | ~txd;
        end
        n_got = n_got + 16'h0001;
    end
endmodule
`default_nettype wire

// *** verif/test_msp_port.sv ***
// Self-checking testbench of the serial port setup block.
`timescale 1ns/100ps
`default_nettype none
module test_msp_port
    import msp_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, cfg_wr = 1'b0, req_valid = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
    logic tx_is_reply = 1'b0, cts = 1'b0, tx_ready, txd, rts, port_active, slave_mode, ascii_mode, tx_busy;
    logic [15:0] cfg_addr = 16'h0000, cfg_wdata = 16'h0000, cfg_rdata, n_got;
    logic [7:0] tx_data = 8'h00, got_byte;
    logic got_err;
    msp_req_type req = '0;
    msp_map_type req_map;
    logic [31:0] seed = 32'hd185, bit_cycles = 32'd1000;
    logic [3:0] nbits = 4'h8;
    logic [1:0] parity = 2'h0, nstop = 2'h1;
    logic [15:0] mem [17];
    logic [7:0] fc [5] = '{8'h02, 8'h04, 8'h03, 8'h06, 8'h10};
    logic [15:0] rates [4] = '{16'h0073, 16'h0240, 16'h0180, 16'hc350};
    int n_mismatch = 0, total_checks = 0;
    msp_port i_msp_port (.clock(clock), .rst(rst), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .req_valid(req_valid), .req(req), .req_map(req_map), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_is_reply(tx_is_reply), .txd(txd),
        .rts(rts), .cts(cts), .port_active(port_active), .slave_mode(slave_mode), .ascii_mode(ascii_mode),
        .tx_busy(tx_busy));
    msp_line_peer i_msp_line_peer (.clock(clock), .txd(txd), .bit_cycles(bit_cycles), .nbits(nbits),
        .parity(parity), .nstop(nstop), .got_byte(got_byte), .got_err(got_err), .n_got(n_got));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [31:0] bps(input logic [15:0] w);
        return w == 16'h0180 ? 32'd38400 : w == 16'h0240 ? 32'd57600 : w == 16'h0073 ? 32'd115000 : {16'h0000, w};
    endfunction
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        if (a >= 16'h1392 && a <= 16'h13a2) mem[a - 16'h1392] = d;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
        @(negedge clock);
        cfg_addr = a;
        #1;
        chk(cfg_rdata === e, "config word readback");
    endtask
    task automatic map_try(input msp_req_type r);
        logic hit, fl;
        logic [15:0] db;
        hit = r.node == mem[14][7:0] && mem[14][15:8] == 8'h00 && mem[0] == 16'h0001 && mem[1] == 16'h0001;
        fl = mem[2] != 16'h0000 && r.addr >= mem[3] && (r.func == 8'h03 || r.func == 8'h06 || r.func == 8'h10);
        db = fl ? r.addr - mem[3] + mem[4] : r.addr + (r.func == 8'h02 ? mem[15] : mem[16]);
        @(negedge clock);
        req_valid = 1'b1;
        req = r;
        @(negedge clock);
        req_valid = 1'b0;
        chk(req_map.hit === hit, "request acceptance");
        if (hit && (fl || r.func == 8'h02 || r.func == 8'h04)) chk(req_map.is_real === fl && req_map.db_addr === db,
            "request target");
    endtask
    task automatic wait_got(input logic [15:0] n);
        for (int w = 0; w < 40000 && n_got !== n; w++) @(negedge clock);
        if (n_got !== n) begin
            chk(1'b0, "no character on the line");
            conclude();
        end
    endtask
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        msp_req_type r;
        logic [15:0] base;
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int k = 0; k < 17; k++) begin
            mem[k] = k == 8 ? 16'h0008 : k == 9 ? 16'h0001 : k == 6 ? 16'h2580 : 16'h0000;
            rd_chk(16'h1392 + k[15:0], mem[k]);
        end
        for (int k = 0; k < 17; k++) begin
            seed = xorshift(seed);
            wr(16'h1392 + k[15:0], seed[15:0]);
        end
        wr(16'h13a3, 16'hffff);
        for (int k = 0; k < 19; k++) rd_chk(16'h1391 + k[15:0], k == 0 || k == 18 ? 16'h0000 : mem[k - 1]);
        for (int k = 0; k < 8; k++) begin
            wr(16'h1392, {15'h0000, k[0]});
            wr(16'h1393, {15'h0000, k[1]});
            wr(16'h1397, {15'h0000, k[2]});
            @(negedge clock);
            chk(port_active === k[0] && slave_mode === k[1] && ascii_mode === k[2], "mode decode");
        end
        wr(16'h13a0, {8'h00, seed[7:0]});
        wr(16'h1394, 16'h0001);
        for (int k = 0; k < 48; k++) begin
            seed = xorshift(seed);
            if (k == 32) wr(16'h1394, 16'h0000);
            if (k == 40) wr(16'h1393, 16'h0000);
            if (k == 44) wr(16'h1392, 16'h0000);
            r.node = k[0] ? mem[14][7:0] : seed[7:0];
            r.func = fc[k % 5];
            r.addr = k[4] ? mem[3] - {15'h0000, k[2]} : seed[31:16];
            map_try(r);
        end
        wr(16'h1392, 16'h0001);
        for (int k = 0; k < 3; k++) wr(16'h139c + k[15:0], 16'h0000);
        for (int k = 0; k < 4; k++) begin
            bit_cycles = 32'd50000000 / bps(rates[k]);
            nbits = 4'h8 - k[3:0];
            parity = 2'(k % 3);
            nstop = k == 1 ? 2'h2 : 2'h1;
            wr(16'h1398, rates[k]);
            wr(16'h1399, {14'h0000, parity});
            wr(16'h139a, {12'h000, nbits});
            wr(16'h139b, {14'h0000, nstop});
            wr(16'h139f, {15'h0000, k[0]});
            cts = 1'b0;
            tx_is_reply = k[1];
            base = n_got;
            for (int j = 0; j < 2; j++) begin
                seed = xorshift(seed);
                mem[j] = {8'h00, seed[7:0] & (8'hff >> (4'h8 - nbits))};
                @(negedge clock);
                tx_valid = 1'b1;
                tx_data = seed[7:0];
                tx_last = j[0];
                chk(tx_ready === 1'b1, "byte refused");
                @(negedge clock);
                tx_valid = 1'b0;
            end
            if (k[0]) begin
                repeat (3000) @(negedge clock);
                chk(n_got === base && txd === 1'b1, "sent while blocked");
                cts = 1'b1;
            end
            for (int j = 0; j < 2; j++) begin
                wait_got(base + j[15:0] + 16'h0001);
                chk(got_byte === mem[j][7:0] && {got_err, rts} === 2'b01, "character");
            end
            for (int w = 0; w < 3000 && rts !== 1'b0; w++) @(negedge clock);
            chk(rts === 1'b0 && tx_busy === 1'b0, "line not released");
        end
        conclude();
    end
endmodule
`default_nettype wire
